// ### design/pfhc_top.sv
// position fault supervision, fast stop, preset and homing control
//
// Operation
// - following error is reference minus feedback count, zero while stopped
// - hard limit input sets error code 1 upper or 2 lower
// - reaction 0 keeps running; 1 blocks output and closes brake if used
// - reaction 2 decelerates on trip time; brake closes at brake frequency
// - upper soft limit checked only when its enable is 1
// - lower soft limit checked only when its enable is 1
// - passing enabled soft limit gives code 3 upper or 4 lower
// - following error at or over maximum gives code 5
// - fast stop input decelerates over the fast stop time
// - fast stop request is latched until the deceleration completes
// - fast stop ignores target and current position
// - preset input loads the position counter with the preset position
// - feedback counts up forward; direction setting 1 inverts the sense
// - homing run input drives motor at homing speed and homing ramp
// - preset rise during homing reverses and creeps at a fifth speed
// - preset fall during homing loads position, then index types stop at index, no-index types stop at once
// - negative homing speed runs the homing motion in reverse
// - homing ramp is time between zero and maximum frequency
// - homing type codes: reverse or forward, with or without index
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pfhc_top #(
    parameter int pos_w = 32
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire pfhc_pkg::pfhc_pins_s pins,
    input  wire pfhc_pkg::pfhc_ref_s  ref_in,
    input  wire logic               drive_running,
    input  wire logic [15:0]        out_freq,
    output pfhc_pkg::pfhc_drive_s   drive
);

    // settings
    logic [7:0]        ctrl_reg;
    logic [31:0]       upper_lev_reg;
    logic [31:0]       lower_lev_reg;
    logic [15:0]       max_track_reg;
    logic [15:0]       preset_pos_reg;
    logic [15:0]       home_speed_reg;
    logic [15:0]       home_ramp_reg;
    logic [15:0]       fstop_time_reg;
    logic [15:0]       brake_freq_reg;
    // state
    logic [pos_w-1:0]  pos_reg;
    logic [pos_w-1:0]  ref_cnt_reg;
    logic [pos_w-1:0]  track_err_reg;
    logic [2:0]        err_code_reg;
    logic              fast_latch_reg;
    logic              free_reg;
    logic              dec_reg;
    logic              brake_reg;
    pfhc_pkg::pfhc_hstate_e hstate_reg;
    logic [15:0]       hspeed_reg;
    logic              pready_reg;
    logic [31:0]       prdata_reg;
    logic              pslverr_reg;
    // pin synchroniser and filter
    logic [pfhc_pkg::pin_w-1:0] s1_reg;
    logic [pfhc_pkg::pin_w-1:0] s2_reg;
    logic [pfhc_pkg::pin_w-1:0] s3_reg;
    logic [pfhc_pkg::pin_w-1:0] filt_reg;
    logic [pfhc_pkg::pin_w-1:0] prev_reg;
    pfhc_pkg::pfhc_pins_s       pf;
    pfhc_pkg::pfhc_pins_s       pp;

    // sign-extend a 16-bit setting to the position width
    function automatic logic [pos_w-1:0] sx16(input logic [15:0] v);
        sx16 = {{(pos_w-16){v[15]}}, v};
    endfunction

    // signed magnitude of a position-width value
    function automatic logic [pos_w-1:0] mag(input logic [pos_w-1:0] v);
        mag = v[pos_w-1] ? (~v + 1'b1) : v;
    endfunction

    assign pf = pfhc_pkg::pfhc_pins_s'(filt_reg);
    assign pp = pfhc_pkg::pfhc_pins_s'(prev_reg);

    // apb decode, one wait state per access
    logic acc;
    logic wr;
    logic hit;
    assign acc = psel & penable & ~pready_reg;
    assign wr  = acc & pwrite;

    always_comb begin
        hit = 1'b1;
        case (paddr)
            pfhc_pkg::ctrl_off, pfhc_pkg::upper_lev_off, pfhc_pkg::lower_lev_off,
            pfhc_pkg::max_track_off, pfhc_pkg::preset_pos_off,
            pfhc_pkg::home_speed_off, pfhc_pkg::home_ramp_off,
            pfhc_pkg::fstop_time_off, pfhc_pkg::brake_freq_off,
            pfhc_pkg::status_off, pfhc_pkg::track_err_off,
            pfhc_pkg::position_off: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // status word: error code, fast stop latch, homing state
    logic [31:0] status_w;
    assign status_w = {26'h0, hstate_reg, fast_latch_reg, err_code_reg};

    // apb answer; unmapped addresses answer with an error and zero data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= acc;
            pslverr_reg <= acc & ~hit;
            prdata_reg  <= 32'h0;
            if (acc && !pwrite) begin
                case (paddr)
                    pfhc_pkg::ctrl_off:       prdata_reg <= {24'h0, ctrl_reg};
                    pfhc_pkg::upper_lev_off:  prdata_reg <= upper_lev_reg;
                    pfhc_pkg::lower_lev_off:  prdata_reg <= lower_lev_reg;
                    pfhc_pkg::max_track_off:  prdata_reg <= {16'h0, max_track_reg};
                    pfhc_pkg::preset_pos_off: prdata_reg <= {16'h0, preset_pos_reg};
                    pfhc_pkg::home_speed_off: prdata_reg <= {16'h0, home_speed_reg};
                    pfhc_pkg::home_ramp_off:  prdata_reg <= {16'h0, home_ramp_reg};
                    pfhc_pkg::fstop_time_off: prdata_reg <= {16'h0, fstop_time_reg};
                    pfhc_pkg::brake_freq_off: prdata_reg <= {16'h0, brake_freq_reg};
                    pfhc_pkg::status_off:     prdata_reg <= status_w;
                    pfhc_pkg::track_err_off:  prdata_reg <= 32'(track_err_reg);
                    pfhc_pkg::position_off:   prdata_reg <= 32'(pos_reg);
                    default:                  prdata_reg <= 32'h0;
                endcase
            end
        end
    end

    // setting registers, written on the access edge only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg       <= pfhc_pkg::ctrl_rst;
            upper_lev_reg  <= pfhc_pkg::upper_lev_rst;
            lower_lev_reg  <= pfhc_pkg::lower_lev_rst;
            max_track_reg  <= pfhc_pkg::max_track_rst;
            preset_pos_reg <= pfhc_pkg::preset_pos_rst;
            home_speed_reg <= pfhc_pkg::home_speed_rst;
            home_ramp_reg  <= pfhc_pkg::home_ramp_rst;
            fstop_time_reg <= pfhc_pkg::fstop_time_rst;
            brake_freq_reg <= pfhc_pkg::brake_freq_rst;
        end else if (wr) begin
            case (paddr)
                pfhc_pkg::ctrl_off:       ctrl_reg       <= pwdata[7:0];
                pfhc_pkg::upper_lev_off:  upper_lev_reg  <= pwdata;
                pfhc_pkg::lower_lev_off:  lower_lev_reg  <= pwdata;
                pfhc_pkg::max_track_off:  max_track_reg  <= pwdata[15:0];
                pfhc_pkg::preset_pos_off: preset_pos_reg <= pwdata[15:0];
                pfhc_pkg::home_speed_off: home_speed_reg <= pwdata[15:0];
                pfhc_pkg::home_ramp_off:  home_ramp_reg  <= pwdata[15:0];
                pfhc_pkg::fstop_time_off: fstop_time_reg <= pwdata[15:0];
                pfhc_pkg::brake_freq_off: brake_freq_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // three-stage pin sync; a change counts once stages two and three agree
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            filt_reg <= '0;
            prev_reg <= '0;
        end else begin
            s1_reg   <= pins;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
            prev_reg <= filt_reg;
        end
    end

    // decoded settings and pin edges
    logic enc_inv;
    logic brake_fn;
    logic up_en;
    logic lo_en;
    logic [1:0] react;
    logic [1:0] htype;
    logic fb_step;
    logic fb_up;
    logic pre_rise;
    logic pre_fall;
    logic home_rise;
    logic idx_rise;
    logic homing;
    assign enc_inv  = ctrl_reg[pfhc_pkg::enc_inv_bit];
    assign brake_fn = ctrl_reg[pfhc_pkg::brake_fn_bit];
    assign up_en    = ctrl_reg[pfhc_pkg::up_en_bit];
    assign lo_en    = ctrl_reg[pfhc_pkg::lo_en_bit];
    assign react    = ctrl_reg[pfhc_pkg::react_lsb +: 2];
    assign htype    = ctrl_reg[pfhc_pkg::htype_lsb +: 2];
    assign fb_step   = pf.fb_pulse & ~pp.fb_pulse;
    assign fb_up     = pf.fb_dir ^ enc_inv;
    assign pre_rise  = pf.preset & ~pp.preset;
    assign pre_fall  = ~pf.preset & pp.preset;
    assign home_rise = pf.homing_run & ~pp.homing_run;
    assign idx_rise  = pf.index_pulse & ~pp.index_pulse;
    assign homing    = (hstate_reg != pfhc_pkg::pfhc_h_idle);

    // position counter: feedback steps, preset load wins over a step
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_reg <= '0;
        end else if ((pre_rise && !homing)
                     || (pre_fall && hstate_reg == pfhc_pkg::pfhc_h_creep)) begin
            pos_reg <= {{(pos_w-16){1'b0}}, preset_pos_reg};
        end else if (fb_step) begin
            pos_reg <= fb_up ? pos_reg + 1'b1 : pos_reg - 1'b1;
        end
    end

    // reference count tracks position while stopped so the error starts at zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ref_cnt_reg <= '0;
        end else if (!drive_running) begin
            ref_cnt_reg <= pos_reg;
        end else if (ref_in.pulse) begin
            ref_cnt_reg <= ref_in.dir ? ref_cnt_reg + 1'b1 : ref_cnt_reg - 1'b1;
        end
    end

    // following error, forced to zero when stopped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            track_err_reg <= '0;
        end else begin
            track_err_reg <= drive_running ? ref_cnt_reg - pos_reg : '0;
        end
    end

    // error detection in fixed priority; codes compare as signed positions
    logic [2:0] new_err;
    always_comb begin
        new_err = pfhc_pkg::pfhc_err_none;
        if (pf.upper_hard_limit_input)
            new_err = pfhc_pkg::pfhc_err_hw_up;
        else if (pf.lower_hard_limit_input)
            new_err = pfhc_pkg::pfhc_err_hw_lo;
        else if (up_en && $signed(pos_reg) > $signed(upper_lev_reg))
            new_err = pfhc_pkg::pfhc_err_sw_up;
        else if (lo_en && $signed(pos_reg) < $signed(lower_lev_reg))
            new_err = pfhc_pkg::pfhc_err_sw_lo;
        else if (drive_running && mag(track_err_reg) >= sx16(max_track_reg)
                 && !max_track_reg[15])
            new_err = pfhc_pkg::pfhc_err_track;
    end

    // first error code holds until the drive stops; once stopped the
    // code follows the detected error each cycle and holds nothing
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            err_code_reg <= pfhc_pkg::pfhc_err_none;
        end else if (err_code_reg == pfhc_pkg::pfhc_err_none) begin
            err_code_reg <= new_err;
        end else if (!drive_running) begin
            err_code_reg <= new_err;
        end
    end

    // stop reaction, taken when an error code first appears
    logic err_new;
    assign err_new = (err_code_reg == pfhc_pkg::pfhc_err_none)
                     && (new_err != pfhc_pkg::pfhc_err_none);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            free_reg <= 1'b0;
            dec_reg  <= 1'b0;
        end else if (err_new) begin
            free_reg <= (react == pfhc_pkg::pfhc_react_free);
            dec_reg  <= (react == pfhc_pkg::pfhc_react_dec);
        end else if (!drive_running) begin
            free_reg <= 1'b0;
            dec_reg  <= 1'b0;
        end
    end

    // brake: at once on free-run, at the brake frequency on decel
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            brake_reg <= 1'b0;
        end else if (!brake_fn) begin
            brake_reg <= 1'b0;
        end else if (free_reg || (err_new && react == pfhc_pkg::pfhc_react_free)) begin
            brake_reg <= 1'b1;
        end else if (dec_reg && out_freq <= brake_freq_reg) begin
            brake_reg <= 1'b1;
        end else if (!drive_running) begin
            brake_reg <= 1'b0;
        end
    end

    // fast stop latch: held through release until the drive has stopped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fast_latch_reg <= 1'b0;
        end else if (pf.fast_stop && drive_running) begin
            fast_latch_reg <= 1'b1;
        end else if (!drive_running) begin
            fast_latch_reg <= 1'b0;
        end
    end

    // homing sequence; dropping the run input abandons it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hstate_reg <= pfhc_pkg::pfhc_h_idle;
        end else if (!pf.homing_run) begin
            hstate_reg <= pfhc_pkg::pfhc_h_idle;
        end else begin
            case (hstate_reg)
                pfhc_pkg::pfhc_h_idle:
                    if (home_rise) hstate_reg <= pfhc_pkg::pfhc_h_run;
                pfhc_pkg::pfhc_h_run:
                    if (pre_rise) hstate_reg <= pfhc_pkg::pfhc_h_creep;
                pfhc_pkg::pfhc_h_creep:
                    if (pre_fall) begin
                        // no-index types stop straight after the load
                        hstate_reg <= htype[0] ? pfhc_pkg::pfhc_h_idle
                                               : pfhc_pkg::pfhc_h_seek;
                    end
                pfhc_pkg::pfhc_h_seek:
                    if (idx_rise) hstate_reg <= pfhc_pkg::pfhc_h_idle;
                default: hstate_reg <= pfhc_pkg::pfhc_h_idle;
            endcase
        end
    end

    // homing speed: signed rpm; start direction by type, sign by setting
    logic [15:0] base_spd;
    logic [15:0] creep_spd;
    always_comb begin
        base_spd = htype[1] ? home_speed_reg : 16'(-home_speed_reg);
        creep_spd = 16'($signed(-base_spd) / pfhc_pkg::creep_div);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hspeed_reg <= 16'h0;
        end else begin
            case (hstate_reg)
                pfhc_pkg::pfhc_h_run:   hspeed_reg <= base_spd;
                pfhc_pkg::pfhc_h_creep: hspeed_reg <= creep_spd;
                pfhc_pkg::pfhc_h_seek:  hspeed_reg <= creep_spd;
                default:                hspeed_reg <= 16'h0;
            endcase
        end
    end

    // drive command outputs; fast stop overrides the homing ramp
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            drive <= '0;
        end else begin
            drive.output_block     <= free_reg;
            drive.trip_decel       <= dec_reg & ~free_reg;
            drive.fast_decel       <= fast_latch_reg;
            drive.brake_close      <= brake_reg;
            drive.homing_active    <= homing & ~fast_latch_reg;
            drive.homing_speed_cmd <= fast_latch_reg ? 16'h0 : hspeed_reg;
            // ramp times are zero-to-maximum-frequency figures
            drive.ramp_time        <= fast_latch_reg ? fstop_time_reg
                                                     : home_ramp_reg;
        end
    end

    assign pready  = pready_reg;
    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;

endmodule

`default_nettype wire

// ### design/pfhc_pkg.sv
// package for the position fault and homing control block
package pfhc_pkg;

    // register byte offsets
    localparam logic [7:0] ctrl_off       = 8'h00;
    localparam logic [7:0] upper_lev_off  = 8'h04;
    localparam logic [7:0] lower_lev_off  = 8'h08;
    localparam logic [7:0] max_track_off  = 8'h0c;
    localparam logic [7:0] preset_pos_off = 8'h10;
    localparam logic [7:0] home_speed_off = 8'h14;
    localparam logic [7:0] home_ramp_off  = 8'h18;
    localparam logic [7:0] fstop_time_off = 8'h1c;
    localparam logic [7:0] brake_freq_off = 8'h20;
    localparam logic [7:0] status_off     = 8'h24;
    localparam logic [7:0] track_err_off  = 8'h28;
    localparam logic [7:0] position_off   = 8'h2c;

    // control register field positions
    localparam int enc_inv_bit   = 0;
    localparam int brake_fn_bit  = 1;
    localparam int up_en_bit     = 2;
    localparam int lo_en_bit     = 3;
    localparam int react_lsb     = 4;
    localparam int htype_lsb     = 6;

    // reset values of the settings
    localparam logic [7:0]  ctrl_rst       = 8'h00;
    localparam logic [31:0] upper_lev_rst  = 32'h0000ea60;
    localparam logic [31:0] lower_lev_rst  = 32'h00001388;
    localparam logic [15:0] max_track_rst  = 16'h7530;
    localparam logic [15:0] preset_pos_rst = 16'h0000;
    localparam logic [15:0] home_speed_rst = 16'h0064;
    localparam logic [15:0] home_ramp_rst  = 16'h000a;
    localparam logic [15:0] fstop_time_rst = 16'h0032;
    localparam logic [15:0] brake_freq_rst = 16'h0000;

    // creep speed is a fifth of the homing speed
    localparam int creep_div = 5;

    // stop reaction codes
    typedef enum logic [1:0] {
        pfhc_react_none = 2'h0,
        pfhc_react_free = 2'h1,
        pfhc_react_dec  = 2'h2
    } pfhc_react_e;

    // error codes shown in status
    typedef enum logic [2:0] {
        pfhc_err_none  = 3'h0,
        pfhc_err_hw_up = 3'h1,
        pfhc_err_hw_lo = 3'h2,
        pfhc_err_sw_up = 3'h3,
        pfhc_err_sw_lo = 3'h4,
        pfhc_err_track = 3'h5
    } pfhc_err_e;

    // homing types: bit 1 forward start, bit 0 no index
    typedef enum logic [1:0] {
        pfhc_home_rev_idx   = 2'h0,
        pfhc_home_rev_noidx = 2'h1,
        pfhc_home_fwd_idx   = 2'h2,
        pfhc_home_fwd_noidx = 2'h3
    } pfhc_htype_e;

    // homing states, gray along the path
    typedef enum logic [1:0] {
        pfhc_h_idle  = 2'b00,
        pfhc_h_run   = 2'b01,
        pfhc_h_creep = 2'b11,
        pfhc_h_seek  = 2'b10
    } pfhc_hstate_e;

    // pin inputs from encoder, switches and command inputs
    typedef struct packed {
        logic fb_pulse;
        logic fb_dir;
        logic index_pulse;
        logic upper_hard_limit_input;
        logic lower_hard_limit_input;
        logic fast_stop;
        logic preset;
        logic homing_run;
    } pfhc_pins_s;

    localparam int pin_w = 8;

    // reference pulse stream from the profile logic, same clock
    typedef struct packed {
        logic pulse;
        logic dir;
    } pfhc_ref_s;

    // drive command outputs
    typedef struct packed {
        logic        output_block;
        logic        trip_decel;
        logic        fast_decel;
        logic        brake_close;
        logic        homing_active;
        logic [15:0] homing_speed_cmd;
        logic [15:0] ramp_time;
    } pfhc_drive_s;

endpackage

// ### verif/pfhc_props.sv
// port assertions for the position fault and homing block
`timescale 1ns/1ps
`default_nettype none
module pfhc_props (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic                  drive_running,
    input wire pfhc_pkg::pfhc_drive_s drive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_ready_after_take: assert property (psel && penable && !pready |=> pready)
        else $error("no answer");
    a_ready_needs_sel: assert property (pready |-> $past(psel && penable))
        else $error("ready unasked");
    a_slverr_with_ready: assert property (pslverr |-> pready) else $error("stray slverr");
    a_data_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
    a_idle_no_ready: assert property (!psel |=> !pready) else $error("ready while idle");
    // the latch may only drop once the drive has stopped
    a_fast_latch_held:
        assert property (drive.fast_decel && drive_running && $past(drive_running)
            && $past(drive_running, 2) |=> drive.fast_decel) else $error("fast stop lost");
    a_quiet_after_reset: assert property ($past(reset) |-> drive == '0 && !pready)
        else $error("outputs not quiet");
    c_slverr: cover property (pslverr);
    c_fast: cover property (drive.fast_decel);
    c_homing: cover property (drive.homing_active);
    c_block: cover property (drive.output_block);
endmodule
`default_nettype wire

// ### verif/pfhc_far_model.sv
// far side: encoder, limit switches and command inputs
`timescale 1ns/1ps
`default_nettype none
module pfhc_far_model (
    input wire logic              clk,
    input wire logic              enc_on,
    input wire logic              enc_rev,
    input wire logic [5:0]        sw,
    output pfhc_pkg::pfhc_pins_s  pins
);
    logic [3:0] phase_reg;
    // phase restarts per burst so a burst holds only whole pulses
    always_ff @(posedge clk) begin
        if (!enc_on || phase_reg == 4'hb)
            phase_reg <= 4'h0;
        else
            phase_reg <= phase_reg + 4'h1;
    end
    // pulses last six clocks so they survive the input filter
    assign pins = {enc_on && phase_reg >= 4'h6, !enc_rev, sw};
endmodule
`default_nettype wire

// ### verif/test_position_fault_and_homing_control.sv
// testbench for the position fault and homing block
`timescale 1ns/1ps
`default_nettype none
module test_position_fault_and_homing_control;
    logic                  clk, reset, psel, penable, pwrite, pready, pslverr;
    logic                  drive_running, enc_on, enc_rev, e;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, q;
    logic [15:0]           out_freq;
    logic [5:0]            sw;
    pfhc_pkg::pfhc_pins_s  pins;
    pfhc_pkg::pfhc_ref_s   ref_in;
    pfhc_pkg::pfhc_drive_s drive;
    int                    n_errors, samples_checked;
    logic [31:0] rst_tab [9] = '{32'(pfhc_pkg::ctrl_rst), pfhc_pkg::upper_lev_rst,
        pfhc_pkg::lower_lev_rst, 32'(pfhc_pkg::max_track_rst), 32'(pfhc_pkg::preset_pos_rst),
        32'(pfhc_pkg::home_speed_rst), 32'(pfhc_pkg::home_ramp_rst),
        32'(pfhc_pkg::fstop_time_rst), 32'(pfhc_pkg::brake_freq_rst)};
    pfhc_top i_pfhc_top (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .pins, .ref_in, .drive_running, .out_freq, .drive);
    pfhc_far_model i_pfhc_far_model (.clk, .enc_on, .enc_rev, .sw, .pins);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until ready is sampled high, then released
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
            @(posedge clk);
        while (pready !== 1'b1 && ++n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            n_errors++;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // pins pass a filter of several clocks, so give them time
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask
    task automatic stop();
        sw <= 6'h00;
        drive_running <= 1'b0;
        settle();
    endtask
    task automatic steps(input int n);
        repeat (n) begin
            ref_in <= 2'b11;
            @(posedge clk);
            ref_in <= 2'b00;
            @(posedge clk);
        end
    endtask
    task automatic enc(input int n);
        enc_on <= 1'b1;
        repeat (12 * n) @(posedge clk);
        enc_on <= 1'b0;
        settle();
    endtask
    task automatic run_err(input logic [31:0] c, input logic [31:0] code);
        wr(pfhc_pkg::ctrl_off, c);
        drive_running <= 1'b1;
        settle();
        rd(pfhc_pkg::status_off, code);
        stop();
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        summarize();
    end
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
        {drive_running, enc_on, enc_rev, out_freq, sw, ref_in} = 27'h0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 9; i++)
            rd(8'(i * 4), rst_tab[i]);
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, e}, 32'h1);
        wr(pfhc_pkg::status_off, 32'h7);
        rd(pfhc_pkg::status_off, 32'h0);
        wr(pfhc_pkg::preset_pos_off, 32'h1234);
        sw <= 6'h02;
        settle();
        rd(pfhc_pkg::position_off, 32'h1234);
        sw <= 6'h00;
        enc(3);
        rd(pfhc_pkg::position_off, 32'h1237);
        wr(pfhc_pkg::ctrl_off, 32'h1);
        enc(3);
        rd(pfhc_pkg::position_off, 32'h1234);
        wr(pfhc_pkg::ctrl_off, 32'h0);
        drive_running <= 1'b1;
        steps(5);
        enc(3);
        rd(pfhc_pkg::track_err_off, 32'h2);
        stop();
        rd(pfhc_pkg::track_err_off, 32'h0);
        // free run with brake: upper first, lower later must not replace it
        wr(pfhc_pkg::ctrl_off, 32'h12);
        drive_running <= 1'b1;
        sw <= 6'h10;
        settle();
        sw <= 6'h08;
        settle();
        rd(pfhc_pkg::status_off, 32'h1);
        check({30'h0, drive.output_block, drive.brake_close}, 32'h3);
        stop();
        wr(pfhc_pkg::brake_freq_off, 32'h32);
        wr(pfhc_pkg::ctrl_off, 32'h22);
        out_freq <= 16'h64;
        drive_running <= 1'b1;
        sw <= 6'h08;
        settle();
        rd(pfhc_pkg::status_off, 32'h2);
        check({30'h0, drive.trip_decel, drive.brake_close}, 32'h2);
        out_freq <= 16'h28;
        settle();
        check({31'h0, drive.brake_close}, 32'h1);
        stop();
        wr(pfhc_pkg::upper_lev_off, 32'h1000);
        run_err(32'h0, 32'h0);
        run_err(32'h8, 32'h4);
        run_err(32'h4, 32'h3);
        wr(pfhc_pkg::ctrl_off, 32'h0);
        wr(pfhc_pkg::max_track_off, 32'h3);
        drive_running <= 1'b1;
        steps(4);
        settle();
        rd(pfhc_pkg::status_off, 32'h5);
        stop();
        drive_running <= 1'b1;
        sw <= 6'h04;
        settle();
        check({15'h0, drive.fast_decel, drive.ramp_time}, {16'h1, pfhc_pkg::fstop_time_rst});
        sw <= 6'h00;
        settle();
        check({31'h0, drive.fast_decel}, 32'h1);
        stop();
        wr(pfhc_pkg::ctrl_off, 32'h80);
        wr(pfhc_pkg::preset_pos_off, 32'h4321);
        drive_running <= 1'b1;
        sw <= 6'h01;
        settle();
        check({15'h0, drive.homing_active, drive.homing_speed_cmd}, 32'h10064);
        check({16'h0, drive.ramp_time}, 32'(pfhc_pkg::home_ramp_rst));
        sw <= 6'h03;
        settle();
        check({16'h0, drive.homing_speed_cmd}, 32'hffec);
        sw <= 6'h01;
        settle();
        rd(pfhc_pkg::position_off, 32'h4321);
        sw <= 6'h21;
        settle();
        check({31'h0, drive.homing_active}, 32'h0);
        stop();
        wr(pfhc_pkg::ctrl_off, 32'h40);
        sw <= 6'h01;
        settle();
        check({16'h0, drive.homing_speed_cmd}, 32'hff9c);
        summarize();
    end
endmodule
bind pfhc_top pfhc_props i_pfhc_props (.clk, .reset, .psel, .penable, .pready, .prdata,
    .pslverr, .drive_running, .drive);
`default_nettype wire
